/* File: hdl/lt_defs.svh */
// Offsets, field positions, reset values and timing counts of the timer
`ifndef LT_DEFS_SVH
`define LT_DEFS_SVH
// Register index (printed offsets), byte address is four times the index
`define IDX_CSR2 8'h08
`define IDX_RELOAD 8'h09
`define IDX_CNT2 8'h0A
`define IDX_CSR1 8'h0B
`define IDX_CAPT 8'h0C
// Word index of a byte address
`define ADDR_LSB 2
// Second control/status fields
`define CSR2_IE 1
`define CSR2_FLAG 0
// First control/status fields
`define CSR1_CIE 7
`define CSR1_CFLAG 6
`define CSR1_DBL 5
`define CSR1_IE 4
`define CSR1_FLAG 3
// Prescaler: oscillator divided by 32
`define PRESC_DIV 5'h1F
// First counter wraps from this value to zero
`define CNT1_TOP 8'hF9
`define CNT2_TOP 8'hFF
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h0000_0000
`endif

/* File: hdl/lt_pkg.sv */
// Types shared by the timer files
package lt_pkg;
	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	// APB answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;
	// Interrupt requests
	typedef struct packed {
		logic tb1;
		logic tb2;
		logic capt;
		logic wake;
	} irq_t;
endpackage

/* File: hdl/pin_sync.sv */
// Two-stage synchroniser with edge detection after the second stage
`timescale 1ns/10ps
module pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin in, clean level and edge out
	input wire logic pin,
	output logic level,
	output logic edge_pulse
);
	// All state of the synchroniser
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_st_t;
	sync_st_t st_q, st_d;

	// Next state: first stage only feeds the second
	always_comb begin
		st_d = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.s2;
	// Either edge of the synchronised level
	assign edge_pulse = st_q.s2 ^ st_q.s3;
endmodule

/* File: hdl/dual_timebase_capture_timer.sv */
// Dual timebase counter with input capture, APB register slave
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "lt_defs.svh"
module dual_timebase_capture_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire lt_pkg::apb_req_t apb_req,
	output lt_pkg::apb_rsp_t apb_rsp,
	// Pin and power mode
	input wire logic capture_input_pin,
	input wire logic halt_mode,
	// Interrupt requests
	output lt_pkg::irq_t irq
);
	import lt_pkg::*;

	// All state of the timer apart from wait_q and the pin synchroniser
	typedef struct packed {
		logic [4:0] presc;
		logic [7:0] cnt1;
		logic dbl_phase;
		logic [7:0] cnt2;
		logic [7:0] reload;
		logic [7:0] capt;
		logic first_timebase_flag;
		logic second_timebase_flag;
		logic capture_flag;
		logic first_timebase_irq_enable;
		logic second_timebase_irq_enable;
		logic capture_irq_enable;
		logic period_double_select;
		logic started;
		logic [31:0] rdata;
	} tmr_st_t;
	tmr_st_t st_q, st_d;

	// Synchronised pin edge
	logic pin_edge;
	// Bus decode
	logic acc, wr, rd;
	// One wait state, set by the first access edge
	logic wait_q;
	logic [7:0] idx;
	// Events this cycle
	logic tick, ovf1, tb1_evt, ovf2, cap_evt;
	// Clearing reads
	logic rd_csr1, rd_csr2, rd_capt;

	// Pin passes two flops before edge logic
	pin_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin(capture_input_pin),
		.level(),
		.edge_pulse(pin_edge)
	);

	// Access acts once, on the first access edge; the wait cycle after it
	// must not clear a flag again and so lose an event set in between
	assign acc = apb_req.psel & apb_req.penable & ~wait_q;
	assign wr = acc & apb_req.pwrite;
	assign rd = acc & ~apb_req.pwrite;
	assign idx = apb_req.paddr[`ADDR_LSB +: 8];
	assign rd_csr1 = rd & (idx == `IDX_CSR1);
	assign rd_csr2 = rd & (idx == `IDX_CSR2);
	assign rd_capt = rd & (idx == `IDX_CAPT);

	// Prescaler tick, frozen in full halt
	assign tick = ~halt_mode & (st_q.presc == `PRESC_DIV);
	// Counter one wrap
	assign ovf1 = tick & (st_q.cnt1 == `CNT1_TOP);
	// Doubling skips every other wrap
	assign tb1_evt = ovf1 & (~st_q.period_double_select | st_q.dbl_phase);
	// Counter two wrap past FFh
	assign ovf2 = tick & st_q.started & (st_q.cnt2 == `CNT2_TOP);
	// Capture only while flag clear
	assign cap_evt = pin_edge & ~st_q.capture_flag;

	// Next-state logic
	always_comb begin
		st_d = st_q;
		// Divide by 32
		if (!halt_mode) begin
			st_d.presc = st_q.presc + 5'h01;
		end
		// Counter two loads reload on first clock after reset
		if (!st_q.started) begin
			st_d.cnt2 = st_q.reload;
			st_d.started = 1'b1;
		end else if (ovf2) begin
			// Latest reload taken only here
			st_d.cnt2 = st_q.reload;
		end else if (tick) begin
			st_d.cnt2 = st_q.cnt2 + 8'h01;
		end
		// Counter one, software has no path to it
		if (ovf1) begin
			st_d.cnt1 = `BYTE_ZERO;
			st_d.dbl_phase = ~st_q.dbl_phase;
		end else if (tick) begin
			st_d.cnt1 = st_q.cnt1 + 8'h01;
		end
		// Clearing reads first, events after so set wins
		if (rd_csr1) begin
			st_d.first_timebase_flag = 1'b0;
		end
		if (rd_csr2) begin
			st_d.second_timebase_flag = 1'b0;
		end
		if (rd_capt) begin
			st_d.capture_flag = 1'b0;
		end
		if (tb1_evt) begin
			st_d.first_timebase_flag = 1'b1;
		end
		if (ovf2) begin
			st_d.second_timebase_flag = 1'b1;
		end
		// Latch counter one on accepted edge
		if (cap_evt) begin
			st_d.capt = st_q.cnt1;
			st_d.capture_flag = 1'b1;
		end
		// Writes: control bits only, flags untouched
		if (wr) begin
			case (idx)
				`IDX_CSR2: begin
					st_d.second_timebase_irq_enable = apb_req.pwdata[`CSR2_IE];
				end
				`IDX_RELOAD: begin
					// Held until next overflow
					st_d.reload = apb_req.pwdata[7:0];
				end
				`IDX_CSR1: begin
					st_d.capture_irq_enable = apb_req.pwdata[`CSR1_CIE];
					st_d.period_double_select = apb_req.pwdata[`CSR1_DBL];
					st_d.first_timebase_irq_enable = apb_req.pwdata[`CSR1_IE];
				end
				default: begin
					// Read-only or unmapped: ignored
				end
			endcase
		end
		// Read data, registered at the access edge
		st_d.rdata = `WORD_ZERO;
		if (rd) begin
			case (idx)
				`IDX_CSR2: begin
					st_d.rdata[`CSR2_IE] = st_q.second_timebase_irq_enable;
					st_d.rdata[`CSR2_FLAG] = st_q.second_timebase_flag;
				end
				`IDX_RELOAD: begin
					st_d.rdata[7:0] = st_q.reload;
				end
				`IDX_CNT2: begin
					st_d.rdata[7:0] = st_q.cnt2;
				end
				`IDX_CSR1: begin
					st_d.rdata[`CSR1_CIE] = st_q.capture_irq_enable;
					st_d.rdata[`CSR1_CFLAG] = st_q.capture_flag;
					st_d.rdata[`CSR1_DBL] = st_q.period_double_select;
					st_d.rdata[`CSR1_IE] = st_q.first_timebase_irq_enable;
					st_d.rdata[`CSR1_FLAG] = st_q.first_timebase_flag;
				end
				`IDX_CAPT: begin
					st_d.rdata[7:0] = st_q.capt;
				end
				default: begin
					st_d.rdata = `WORD_ZERO;
				end
			endcase
		end
	end

	// State register; capture flag resets clear, software still reads once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Read data is presented in the cycle after the access edge, so the
	// slave adds one wait state: pready rises on the second access cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= apb_req.psel & apb_req.penable & ~wait_q;
		end
	end

	// Answer: pready on the second access cycle, unmapped answers error
	always_comb begin
		apb_rsp.pready = wait_q;
		apb_rsp.pslverr = wait_q & (idx < `IDX_CSR2 || idx > `IDX_CAPT);
		apb_rsp.prdata = st_q.rdata;
	end

	// Interrupt levels follow flags and enables
	always_comb begin
		irq.tb1 = st_q.first_timebase_flag & st_q.first_timebase_irq_enable;
		irq.tb2 = st_q.second_timebase_flag & st_q.second_timebase_irq_enable;
		irq.capt = st_q.capture_flag & st_q.capture_irq_enable;
		// Capture alone wakes from halt
		irq.wake = irq.capt;
	end

	// Counter one never passes F9h
	AST_CNT1_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.cnt1 <= `CNT1_TOP)
		else $error("counter one above top");
	// Wrap returns to zero
	AST_CNT1_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		ovf1 |=> st_q.cnt1 == `BYTE_ZERO)
		else $error("counter one not zero");
	// Counter one steps by one on a plain tick
	AST_CNT1_STEP: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !ovf1 |=> st_q.cnt1 == $past(st_q.cnt1) + 8'h01)
		else $error("counter one step wrong");
	// Overflow reloads counter two
	AST_CNT2_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
		ovf2 |=> st_q.cnt2 == $past(st_q.reload))
		else $error("no reload");
	// Counter two steps by one below FFh
	AST_CNT2_STEP: assert property (@(posedge clk) disable iff (!rst_n)
		tick && st_q.started && !ovf2 |=> st_q.cnt2 == $past(st_q.cnt2) + 8'h01)
		else $error("counter two step wrong");
	// Halt freezes both counters
	AST_HALT_STOP: assert property (@(posedge clk) disable iff (!rst_n)
		halt_mode && st_q.started |=> $stable(st_q.cnt1) && $stable(st_q.cnt2))
		else $error("count in halt");
	// Prescaler freezes too, so leaving halt neither loses nor gains a tick
	AST_HALT_PRESC: assert property (@(posedge clk) disable iff (!rst_n)
		halt_mode |=> $stable(st_q.presc))
		else $error("prescaler runs in halt");
	// Event sets flag even when read clears it
	AST_TB1_SET: assert property (@(posedge clk) disable iff (!rst_n)
		tb1_evt |=> st_q.first_timebase_flag)
		else $error("flag one lost");
	// Read clears flag one when no event
	AST_TB1_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		rd_csr1 && !tb1_evt |=> !st_q.first_timebase_flag)
		else $error("flag one kept");
	// Flag one stays set until its read
	AST_TB1_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.first_timebase_flag && !rd_csr1 |=> st_q.first_timebase_flag)
		else $error("flag one dropped");
	// Only an event raises flag one, never a write
	AST_TB1_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		!tb1_evt && !st_q.first_timebase_flag |=> !st_q.first_timebase_flag)
		else $error("flag one raised");
	// Overflow two sets flag two even during its clearing read
	AST_TB2_SET: assert property (@(posedge clk) disable iff (!rst_n)
		ovf2 |=> st_q.second_timebase_flag)
		else $error("flag two lost");
	// Read clears flag when no event
	AST_TB2_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		rd_csr2 && !ovf2 |=> !st_q.second_timebase_flag)
		else $error("flag two kept");
	// Only overflow raises flag two, never a write
	AST_TB2_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		!ovf2 && !st_q.second_timebase_flag |=> !st_q.second_timebase_flag)
		else $error("flag two raised");
	// Capture value frozen while flag set
	AST_CAPT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.capture_flag |=> $stable(st_q.capt))
		else $error("capture overwritten");
	// Accepted edge latches counter one
	AST_CAPT_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
		cap_evt |=> st_q.capture_flag && st_q.capt == $past(st_q.cnt1))
		else $error("capture missed");
	// Read of the capture register clears its flag
	AST_CAPT_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		rd_capt && !cap_evt |=> !st_q.capture_flag)
		else $error("capture flag kept");
	// Capture flag stays set until that read
	AST_CAPT_FLAG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.capture_flag && !rd_capt |=> st_q.capture_flag)
		else $error("capture flag dropped");
	// Only an accepted edge raises the capture flag
	AST_CAPT_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		!cap_evt && !st_q.capture_flag |=> !st_q.capture_flag)
		else $error("capture flag raised");
	// Doubling: events 500 ticks apart, so none within a 250-tick period
	AST_DBL: assert property (@(posedge clk) disable iff (!rst_n)
		ovf1 && st_q.period_double_select && !tb1_evt |-> !st_q.dbl_phase)
		else $error("doubling broken");
endmodule

/* File: test/cap_pin_model.sv */
// Outside signal source driving the capture pin
`timescale 1ns/10ps
module cap_pin_model (
	// Clock
	input wire logic clk,
	// Flip request in, pin out
	input wire logic flip,
	output logic pin
);
	// Pin idles low; each request flips it once, just after an edge
	// One process owns the pin, so it has a single driver
	initial begin
		pin = 1'b0;
		forever begin
			@(posedge clk);
			if (flip) begin
				pin <= ~pin;
			end
		end
	end
endmodule

/* File: test/tb_top.sv */
// Register level bench of the timer
`timescale 1ns/10ps
`include "lt_defs.svh"
module tb_top;
	import lt_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic halt = 1'b0;
	logic flip = 1'b0;
	logic pin;
	irq_t irq;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] q;
	logic [31:0] a;
	logic e;
	time t0;
	time t1;
	// Free running 50 MHz clock
	initial forever #10 clk = ~clk;
	dual_timebase_capture_timer i_dut (.clk(clk), .rst_n(rst_n), .apb_req(req),
		.apb_rsp(rsp), .capture_input_pin(pin), .halt_mode(halt), .irq(irq));
	cap_pin_model i_pin (.clk(clk), .flip(flip), .pin(pin));
	// Verdict, one place only
	task end_of_test();
		$display("checks %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Hang guard, well above the longest wait
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			miscompares++;
			end_of_test();
		end
	end
	// Compare and report
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer; pready looked at mid-cycle so the edge is race free
	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		req.psel <= 1'b1;
		req.pwrite <= wr;
		req.paddr <= {22'h0, idx, 2'b00};
		req.pwdata <= wd;
		@(posedge clk);
		req.penable <= 1'b1;
		@(negedge clk);
		while (rsp.pready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		// A slave that never answers counts as a mismatch
		if (rsp.pready !== 1'b1) begin
			miscompares++;
		end
		q = rsp.prdata;
		e = rsp.pslverr;
		@(posedge clk);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// Masked read compare
	task rdc(input string name, input logic [7:0] idx, input logic [31:0] m,
		input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(name, q & m, exp);
	endtask
	// Wait for a first timebase request, then clear it by reading
	task wait_rise(output time t);
		int n;
		n = 0;
		@(negedge clk);
		while (irq.tb1 !== 1'b1 && n < 40000) begin
			@(negedge clk);
			n++;
		end
		// An event that never comes counts as a mismatch
		if (irq.tb1 !== 1'b1) begin
			miscompares++;
		end
		t = $time;
		rdc("tb1 flag", `IDX_CSR1, 32'h08, 32'h08);
		@(negedge clk);
		check("tb1 irq", 32'(irq.tb1), 32'h0);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rdc("capture reset", `IDX_CAPT, 32'hFF, 32'h0);
		rdc("csr2 reset", `IDX_CSR2, 32'hFF, 32'h0);
		rdc("reload reset", `IDX_RELOAD, 32'hFF, 32'h0);
		rdc("csr1 reset", `IDX_CSR1, 32'hFF, 32'h0);
		apb(1'b0, 8'h0D, 32'h0);
		check("unmapped err", 32'(e), 32'h1);
		apb(1'b1, `IDX_RELOAD, 32'hF0);
		apb(1'b1, `IDX_CSR1, 32'hD8);
		rdc("csr1 flags kept", `IDX_CSR1, 32'hF8, 32'h90);
		apb(1'b1, `IDX_CSR2, 32'h03);
		rdc("csr2 flag kept", `IDX_CSR2, 32'h03, 32'h02);
		apb(1'b0, `IDX_CNT2, 32'h0);
		check("cnt2 from zero", 32'(q[7:0] < 8'h10), 32'h1);
		$display("register test done");
		// Capture at tick 100, second edge while flag set
		wait_rise(t0);
		while ($time < t0 + 64000) @(posedge clk);
		flip <= 1'b1;
		@(posedge clk);
		flip <= 1'b0;
		repeat (1280) @(posedge clk);
		flip <= 1'b1;
		@(posedge clk);
		flip <= 1'b0;
		repeat (10) @(posedge clk);
		check("capt irq", 32'({irq.capt, irq.wake}), 32'h3);
		rdc("capt flag", `IDX_CSR1, 32'h40, 32'h40);
		apb(1'b0, `IDX_CAPT, 32'h0);
		check("capt value", 32'(q[7:0] > 8'h62 && q[7:0] < 8'h66), 32'h1);
		rdc("capt clear", `IDX_CSR1, 32'h40, 32'h0);
		wait_rise(t1);
		check("tb1 period", 32'((t1 - t0) / 20), 32'd8000);
		$display("capture test done");
		// Second timebase after many reloads
		check("tb2 irq", 32'(irq.tb2), 32'h1);
		rdc("tb2 flag", `IDX_CSR2, 32'h01, 32'h01);
		rdc("tb2 clear", `IDX_CSR2, 32'h01, 32'h0);
		apb(1'b0, `IDX_CNT2, 32'h0);
		check("cnt2 reloaded", 32'(q[7:0] >= 8'hF0), 32'h1);
		$display("reload test done");
		// Doubled period
		apb(1'b1, `IDX_CSR1, 32'hB0);
		wait_rise(t0);
		wait_rise(t1);
		check("tb1 double", 32'((t1 - t0) / 20), 32'd16000);
		$display("double test done");
		// Full halt freezes counting; mode changes on a rising edge
		@(posedge clk);
		halt <= 1'b1;
		apb(1'b0, `IDX_CNT2, 32'h0);
		a = q;
		repeat (200) @(posedge clk);
		rdc("cnt2 frozen", `IDX_CNT2, 32'hFF, a & 32'hFF);
		halt <= 1'b0;
		repeat (200) @(posedge clk);
		apb(1'b0, `IDX_CNT2, 32'h0);
		check("cnt2 runs", 32'(q !== a), 32'h1);
		$display("halt test done");
		end_of_test();
	end
endmodule
